/* File: pkg/gpt_regs.svh */
// register offsets, field positions and reset values of the timer block
// assumes byte addresses on an 8-bit register port, one 32-bit word per register
`ifndef GPT_REGS_SVH
`define GPT_REGS_SVH

// register offsets
`define GPT_CFG_OFS 8'h00
`define GPT_CTLA_OFS 8'h04
`define GPT_CTLB_OFS 8'h08
`define GPT_LOADA_OFS 8'h0C
`define GPT_LOADB_OFS 8'h10
`define GPT_MATCHA_OFS 8'h14
`define GPT_MATCHB_OFS 8'h18
`define GPT_VALA_OFS 8'h1C
`define GPT_VALB_OFS 8'h20
`define GPT_CAPA_OFS 8'h24
`define GPT_CAPB_OFS 8'h28
`define GPT_VAL32_OFS 8'h2C
`define GPT_STAT_OFS 8'h30
`define GPT_MASK_OFS 8'h34

// configuration fields: width mode in bits 1:0
`define GPT_CFG_W 5
`define GPT_CFG_EN32 2
`define GPT_CFG_PER32 3
`define GPT_CFG_ADC 4

// per-half control fields: mode in bits 2:1, prescale in bits 15:8
`define GPT_CTL_W 16
`define GPT_CTL_EN 0
`define GPT_CTL_CNTEV 3
`define GPT_CTL_INV 4
`define GPT_CTL_FALL 5

// status and mask bits: half i timeout at 2*i, half i capture at 2*i+1
`define GPT_ST_W 6
`define GPT_ST_TO32 4
`define GPT_ST_RTC 5

// reset values
`define GPT_CFG_RST 5'h00
`define GPT_CTL_RST 16'h0000
`define GPT_LOAD_RST 16'hFFFF
`define GPT_MATCH_RST 16'h0000
`define GPT_MASK_RST 6'h00
`define GPT_STAT_RST 6'h00

`endif

/* File: pkg/gpt_pkg.sv */
// types shared by the timer block modules
// assumes nothing beyond a SystemVerilog compiler
package gpt_pkg;
  // mode of one 16-bit half
  typedef enum logic [1:0] {
    GPT_ONESHOT = 2'h0,
    GPT_PERIODIC = 2'h1,
    GPT_CAPTURE = 2'h2,
    GPT_PWM = 2'h3
  } gpt_hmode_t;
  // how the two halves are joined; code 3 is illegal and runs nothing
  typedef enum logic [1:0] {
    GPT_PAIR16 = 2'h0,
    GPT_TIMER32 = 2'h1,
    GPT_RTC32 = 2'h2
  } gpt_width_t;
  // run state of a counter
  typedef enum logic [2:0] {
    GPT_IDLE = 3'b001,
    GPT_RUN = 3'b010,
    GPT_DONE = 3'b100
  } gpt_run_t;
endpackage : gpt_pkg

/* File: pkg/gpt_half_if.sv */
// carrier between the timer top and one 16-bit half
// assumes gpt_pkg is compiled first
`timescale 1ns/1ns
interface gpt_half_if;
  logic en;
  gpt_pkg::gpt_hmode_t mode;
  logic count_ev;
  logic invert;
  logic edge_fall;
  logic [7:0] prescale;
  logic [15:0] load;
  logic [15:0] match;
  logic pin_rise;
  logic pin_fall;
  logic [15:0] value;
  logic [15:0] cap;
  logic timeout;
  logic captured;
  logic pwm;
  logic pwm_oe;
  modport ctl (
    output en, mode, count_ev, invert, edge_fall, prescale, load, match, pin_rise, pin_fall,
    input value, cap, timeout, captured, pwm, pwm_oe
  );
  modport half (
    input en, mode, count_ev, invert, edge_fall, prescale, load, match, pin_rise, pin_fall,
    output value, cap, timeout, captured, pwm, pwm_oe
  );
endinterface : gpt_half_if

/* File: design/gpt_half.sv */
// one 16-bit timer/counter half: one-shot, periodic, capture, pwm
// assumes pin edges arrive already synchronised and filtered by the top
`timescale 1ns/1ns
module gpt_half (
  // clock, reset, clock enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // control and results
  gpt_half_if.half bus
);

  gpt_pkg::gpt_run_t st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] cap_reg, cap_next;
  logic [7:0] pre_reg, pre_next;
  logic to_reg, to_next;
  logic capd_reg, capd_next;
  logic pwm_reg, pwm_next;
  logic pin_edge;
  logic tick;
  logic timing;

  //////////////////////////////////////////////////////////////////////////////
  // tick source
  assign pin_edge = bus.edge_fall ? bus.pin_fall : bus.pin_rise;
  assign timing = (bus.mode == gpt_pkg::GPT_ONESHOT) || (bus.mode == gpt_pkg::GPT_PERIODIC);
  // capture and pwm need a time base, so only one-shot and periodic may count pin edges
  assign tick = (bus.count_ev && timing) ? pin_edge : (pre_reg == 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // next state of the counter
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    pre_next = pre_reg;
    cap_next = cap_reg;
    to_next = 1'b0;
    capd_next = 1'b0;
    unique case (st_reg)
      gpt_pkg::GPT_IDLE: begin
        if (bus.en) begin
          st_next = gpt_pkg::GPT_RUN;
          cnt_next = bus.load;
          pre_next = bus.prescale;
        end
      end
      gpt_pkg::GPT_RUN: begin
        if (!bus.en) begin
          st_next = gpt_pkg::GPT_IDLE;
        end else begin
          pre_next = (pre_reg == 8'h00) ? bus.prescale : pre_reg - 8'h01;
          if (tick) begin
            if (cnt_reg == 16'h0000) begin
              to_next = 1'b1;
              if (bus.mode == gpt_pkg::GPT_ONESHOT) begin
                st_next = gpt_pkg::GPT_DONE;
              end else begin
                cnt_next = bus.load;
              end
            end else begin
              cnt_next = cnt_reg - 16'h0001;
            end
          end
          if ((bus.mode == gpt_pkg::GPT_CAPTURE) && pin_edge) begin
            cap_next = cnt_reg;
            capd_next = 1'b1;
          end
        end
      end
      gpt_pkg::GPT_DONE: begin
        // a one-shot stays stopped until software drops the enable
        if (!bus.en) begin
          st_next = gpt_pkg::GPT_IDLE;
        end
      end
      default: st_next = gpt_pkg::GPT_IDLE;
    endcase
    // high while count is above the match value, then optionally inverted
    pwm_next = ((bus.mode == gpt_pkg::GPT_PWM) && (st_reg == gpt_pkg::GPT_RUN)
                && (cnt_reg > bus.match)) ^ bus.invert;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= gpt_pkg::GPT_IDLE;
      cnt_reg <= 16'h0000;
      cap_reg <= 16'h0000;
      pre_reg <= 8'h00;
      to_reg <= 1'b0;
      capd_reg <= 1'b0;
      pwm_reg <= 1'b0;
    end else if (ce_in) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      cap_reg <= cap_next;
      pre_reg <= pre_next;
      to_reg <= to_next;
      capd_reg <= capd_next;
      pwm_reg <= pwm_next;
    end
  end

  assign bus.value = cnt_reg;
  assign bus.cap = cap_reg;
  assign bus.timeout = to_reg;
  assign bus.captured = capd_reg;
  assign bus.pwm = pwm_reg;
  assign bus.pwm_oe = bus.en && (bus.mode == gpt_pkg::GPT_PWM);

endmodule : gpt_half

/* File: design/gpt_top.sv */
// general-purpose timer block: two 16-bit halves, or one 32-bit timer or clock
// assumes a single clock, a plain register port and pins that arrive asynchronously
//
// How it works
// - Two 16-bit halves each run on their own as a timer or as a counter of pin events.
// - The halves can instead be joined into one 32-bit timer or one 32-bit real-time clock.
// - Joined, the block runs as real-time clock, one-shot timer or periodic timer.
// - Separate, each half runs one-shot or periodic and may use an 8-bit prescaler.
// - A separate half can also capture its count on a pin edge or generate pwm.
// - Events on the capture/compare pins, made outside, are counted or timed.
// - A time-out can raise a trigger that starts an analog-to-digital conversion.
// - In pwm mode the pin carries a simple pwm wave that software may invert.
`timescale 1ns/1ns
`include "gpt_regs.svh"
module gpt_top (
  // clock, reset, clock enable
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // capture/compare/pwm pins, bit 0 for half a, bit 1 for half b
  input wire logic [1:0] capture_compare_pwm_pin_in,
  output logic [1:0] capture_compare_pwm_pin_out,
  output logic [1:0] capture_compare_pwm_pin_oe_out,
  // system outputs
  output logic adc_trigger_out,
  output logic irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [`GPT_CFG_W-1:0] cfg_reg, cfg_next;
  logic [`GPT_CTL_W-1:0] ctl_reg [2];
  logic [`GPT_CTL_W-1:0] ctl_next [2];
  logic [15:0] load_reg [2];
  logic [15:0] load_next [2];
  logic [15:0] match_reg [2];
  logic [15:0] match_next [2];
  logic [`GPT_ST_W-1:0] mask_reg, mask_next;
  logic [`GPT_ST_W-1:0] stat_reg, stat_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] s1_reg, s2_reg, s3_reg, stab_reg;
  logic [1:0] s1_next, s2_next, s3_next, stab_next;
  logic [1:0] pin_rise, pin_fall;
  gpt_pkg::gpt_run_t st32_reg, st32_next;
  logic [31:0] cnt32_reg, cnt32_next;
  logic to32_reg, to32_next;
  logic rtc_reg, rtc_next;
  logic adc_reg, adc_next;
  gpt_pkg::gpt_width_t width;
  logic pair_mode;
  logic run32;
  logic [31:0] load32;
  logic [31:0] match32;
  logic [31:0] cnt32_inc;
  wire logic [1:0] to16;
  wire logic [1:0] cap16;
  wire logic [15:0] val16 [2];
  wire logic [15:0] capv16 [2];
  logic [`GPT_ST_W-1:0] events;
  logic wr_stat;

  //////////////////////////////////////////////////////////////////////////////
  // configuration decode
  assign width = gpt_pkg::gpt_width_t'(cfg_reg[1:0]);
  assign pair_mode = (width == gpt_pkg::GPT_PAIR16);
  assign run32 = ((width == gpt_pkg::GPT_TIMER32) || (width == gpt_pkg::GPT_RTC32))
                 && cfg_reg[`GPT_CFG_EN32];
  assign load32 = {load_reg[1], load_reg[0]};
  assign match32 = {match_reg[1], match_reg[0]};
  assign cnt32_inc = cnt32_reg + 32'h0000_0001;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  always_comb begin
    s1_next = capture_compare_pwm_pin_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    // a new level counts only once stages two and three agree
    stab_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stab_reg);
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
      stab_reg <= 2'h0;
    end else if (ce_in) begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      stab_reg <= stab_next;
    end
  end

  // one-cycle edge pulses of the filtered pin levels
  assign pin_rise = s2_reg & s3_reg & ~stab_reg;
  assign pin_fall = ~s2_reg & ~s3_reg & stab_reg;

  //////////////////////////////////////////////////////////////////////////////
  // the two 16-bit halves
  for (genvar i = 0; i < 2; i++) begin : g_half
    gpt_half_if hif ();
    // halves are held off while joined, so they never fight the 32-bit counter
    assign hif.en = pair_mode && ctl_reg[i][`GPT_CTL_EN];
    assign hif.mode = gpt_pkg::gpt_hmode_t'(ctl_reg[i][2:1]);
    assign hif.count_ev = ctl_reg[i][`GPT_CTL_CNTEV];
    assign hif.invert = ctl_reg[i][`GPT_CTL_INV];
    assign hif.edge_fall = ctl_reg[i][`GPT_CTL_FALL];
    assign hif.prescale = ctl_reg[i][15:8];
    assign hif.load = load_reg[i];
    assign hif.match = match_reg[i];
    assign hif.pin_rise = pin_rise[i];
    assign hif.pin_fall = pin_fall[i];
    assign to16[i] = hif.timeout;
    assign cap16[i] = hif.captured;
    assign val16[i] = hif.value;
    assign capv16[i] = hif.cap;
    assign capture_compare_pwm_pin_out[i] = hif.pwm;
    assign capture_compare_pwm_pin_oe_out[i] = hif.pwm_oe;
    gpt_half u_half (
      .clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .bus(hif.half)
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // joined 32-bit timer or real-time clock
  always_comb begin
    st32_next = st32_reg;
    cnt32_next = cnt32_reg;
    to32_next = 1'b0;
    rtc_next = 1'b0;
    unique case (st32_reg)
      gpt_pkg::GPT_IDLE: begin
        if (run32) begin
          st32_next = gpt_pkg::GPT_RUN;
          cnt32_next = load32;
        end
      end
      gpt_pkg::GPT_RUN: begin
        if (!run32) begin
          st32_next = gpt_pkg::GPT_IDLE;
        end else if (width == gpt_pkg::GPT_RTC32) begin
          // the clock counts up once per rising edge of the reference on pin a
          if (pin_rise[0]) begin
            cnt32_next = cnt32_inc;
            rtc_next = (cnt32_inc == match32);
          end
        end else if (cnt32_reg == 32'h0000_0000) begin
          to32_next = 1'b1;
          if (cfg_reg[`GPT_CFG_PER32]) begin
            cnt32_next = load32;
          end else begin
            st32_next = gpt_pkg::GPT_DONE;
          end
        end else begin
          cnt32_next = cnt32_reg - 32'h0000_0001;
        end
      end
      gpt_pkg::GPT_DONE: begin
        if (!run32) begin
          st32_next = gpt_pkg::GPT_IDLE;
        end
      end
      default: st32_next = gpt_pkg::GPT_IDLE;
    endcase
    // any time-out may start a conversion when enabled
    adc_next = cfg_reg[`GPT_CFG_ADC] && (to32_reg || (|to16));
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st32_reg <= gpt_pkg::GPT_IDLE;
      cnt32_reg <= 32'h0000_0000;
      to32_reg <= 1'b0;
      rtc_reg <= 1'b0;
      adc_reg <= 1'b0;
    end else if (ce_in) begin
      st32_reg <= st32_next;
      cnt32_reg <= cnt32_next;
      to32_reg <= to32_next;
      rtc_reg <= rtc_next;
      adc_reg <= adc_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file and interrupt status
  assign events = {rtc_reg, to32_reg, cap16[1], to16[1], cap16[0], to16[0]};
  assign wr_stat = wr_in && (addr_in == `GPT_STAT_OFS);

  always_comb begin
    cfg_next = cfg_reg;
    ctl_next = ctl_reg;
    load_next = load_reg;
    match_next = match_reg;
    mask_next = mask_reg;
    if (wr_in) begin
      unique case (addr_in)
        `GPT_CFG_OFS: cfg_next = wdata_in[`GPT_CFG_W-1:0];
        `GPT_CTLA_OFS: ctl_next[0] = wdata_in[`GPT_CTL_W-1:0];
        `GPT_CTLB_OFS: ctl_next[1] = wdata_in[`GPT_CTL_W-1:0];
        `GPT_LOADA_OFS: load_next[0] = wdata_in[15:0];
        `GPT_LOADB_OFS: load_next[1] = wdata_in[15:0];
        `GPT_MATCHA_OFS: match_next[0] = wdata_in[15:0];
        `GPT_MATCHB_OFS: match_next[1] = wdata_in[15:0];
        `GPT_MASK_OFS: mask_next = wdata_in[`GPT_ST_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear written in the same cycle
    stat_next = (stat_reg & ~(wr_stat ? wdata_in[`GPT_ST_W-1:0] : 6'h00)) | events;
  end

  // read data stand in the cycle after the strobe only
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_in) begin
      unique case (addr_in)
        `GPT_CFG_OFS: rdata_next = {27'h0, cfg_reg};
        `GPT_CTLA_OFS: rdata_next = {16'h0000, ctl_reg[0]};
        `GPT_CTLB_OFS: rdata_next = {16'h0000, ctl_reg[1]};
        `GPT_LOADA_OFS: rdata_next = {16'h0000, load_reg[0]};
        `GPT_LOADB_OFS: rdata_next = {16'h0000, load_reg[1]};
        `GPT_MATCHA_OFS: rdata_next = {16'h0000, match_reg[0]};
        `GPT_MATCHB_OFS: rdata_next = {16'h0000, match_reg[1]};
        `GPT_VALA_OFS: rdata_next = {16'h0000, val16[0]};
        `GPT_VALB_OFS: rdata_next = {16'h0000, val16[1]};
        `GPT_CAPA_OFS: rdata_next = {16'h0000, capv16[0]};
        `GPT_CAPB_OFS: rdata_next = {16'h0000, capv16[1]};
        `GPT_VAL32_OFS: rdata_next = cnt32_reg;
        `GPT_STAT_OFS: rdata_next = {26'h0, stat_reg};
        `GPT_MASK_OFS: rdata_next = {26'h0, mask_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_reg <= `GPT_CFG_RST;
      ctl_reg <= '{`GPT_CTL_RST, `GPT_CTL_RST};
      load_reg <= '{`GPT_LOAD_RST, `GPT_LOAD_RST};
      match_reg <= '{`GPT_MATCH_RST, `GPT_MATCH_RST};
      mask_reg <= `GPT_MASK_RST;
      stat_reg <= `GPT_STAT_RST;
      rdata_reg <= 32'h0000_0000;
    end else if (ce_in) begin
      cfg_reg <= cfg_next;
      ctl_reg <= ctl_next;
      load_reg <= load_next;
      match_reg <= match_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_out = rdata_reg;
  assign adc_trigger_out = adc_reg;
  assign irq_out = |(stat_reg & mask_reg);

endmodule : gpt_top

/* File: verif/gpt_top_properties.sv */
// port-level assertions for the timer block top
// assumes the offsets of gpt_regs.svh and a single clock domain
`timescale 1ns/1ns
`include "gpt_regs.svh"
module gpt_top_properties (
  // clock and control
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // pins and system outputs
  input wire logic [1:0] capture_compare_pwm_pin_in,
  input wire logic [1:0] capture_compare_pwm_pin_out,
  input wire logic [1:0] capture_compare_pwm_pin_oe_out,
  input wire logic adc_trigger_out,
  input wire logic irq_out
);
  logic [15:0] wdata_low;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  // low half of write data, kept apart so $past sees a plain signal
  assign wdata_low = wdata_in[15:0];
  // a load write followed at once by its read back
  sequence s_load_wr;
    wr_in && ce_in && addr_in == `GPT_LOADA_OFS;
  endsequence
  sequence s_load_rd;
    rd_in && ce_in && addr_in == `GPT_LOADA_OFS;
  endsequence
  // trigger switched off, then a cycle with no new config write
  sequence s_adc_off;
    wr_in && ce_in && addr_in == `GPT_CFG_OFS && !wdata_in[`GPT_CFG_ADC] ##1
      ce_in && !(wr_in && addr_in == `GPT_CFG_OFS);
  endsequence
  ////////////////////////////////////////
  rd_idle_a: assert property (ce_in && !rd_in |=> rdata_out == 32'h0)
    else $error("read data without a read strobe");
  load_back_a: assert property (s_load_wr ##1 s_load_rd |=>
    rdata_out == {16'h0000, $past(wdata_low, 2)}) else $error("load register read back wrong");
  rd_hole_a: assert property (rd_in && ce_in && addr_in > `GPT_MASK_OFS |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  ctl_upper_a: assert property (rd_in && ce_in && (addr_in == `GPT_CTLA_OFS || addr_in == `GPT_CTLB_OFS)
    |=> rdata_out[31:16] == 16'h0000) else $error("control upper bits not zero");
  mask_irq_a: assert property (wr_in && ce_in && addr_in == `GPT_MASK_OFS && wdata_in[5:0] == 6'h00
    |=> !irq_out) else $error("interrupt with all sources masked");
  adc_gate_a: assert property (s_adc_off |=> !adc_trigger_out)
    else $error("conversion trigger while disabled");
  oe_off_a: assert property (wr_in && ce_in && addr_in == `GPT_CTLA_OFS && !wdata_in[`GPT_CTL_EN]
    |=> capture_compare_pwm_pin_oe_out[0] == 1'b0) else $error("pin driven by a disabled half");
  reset_quiet_a: assert property ($rose(rst_b_in) |-> capture_compare_pwm_pin_out == 2'h0 &&
    capture_compare_pwm_pin_oe_out == 2'h0 && !irq_out && !adc_trigger_out && rdata_out == 32'h0)
    else $error("outputs not quiet after reset");
  ce_hold_a: assert property (!ce_in |=> $stable(rdata_out) && $stable(capture_compare_pwm_pin_out)
    && $stable(adc_trigger_out) && $stable(irq_out)) else $error("outputs moved with clock enable low");
endmodule : gpt_top_properties

bind gpt_top gpt_top_properties u_props (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .capture_compare_pwm_pin_in(capture_compare_pwm_pin_in),
  .capture_compare_pwm_pin_out(capture_compare_pwm_pin_out),
  .capture_compare_pwm_pin_oe_out(capture_compare_pwm_pin_oe_out),
  .adc_trigger_out(adc_trigger_out), .irq_out(irq_out)
);

/* File: verif/gpt_pin_model.sv */
// event source and pwm load on the two capture/compare pins
// assumes pulse() is called just after a rising clock edge
`timescale 1ns/1ns
module gpt_pin_model (
  // clock
  input wire logic clk_in,
  // pins
  output logic [1:0] pin_out,
  input wire logic [1:0] pwm_in,
  input wire logic [1:0] oe_in
);
  int hi_cnt[2] = '{0, 0};
  initial pin_out = 2'h0;
  ////////////////////////////////////////
  // one edge pair; each level held w cycles, so w of 2 is the fastest legal source
  task automatic pulse(input int i, input int w);
    pin_out[i] <= 1'b1;
    repeat (w) @(posedge clk_in);
    pin_out[i] <= 1'b0;
    repeat (w) @(posedge clk_in);
  endtask : pulse
  // load: counts driven-high cycles, by nba so bench reads never race it
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (oe_in[i] === 1'b1 && pwm_in[i] === 1'b1) hi_cnt[i] <= hi_cnt[i] + 1;
    end
  end
endmodule : gpt_pin_model

/* File: verif/gpt_top_tb.sv */
// self-checking bench for the timer block top
// assumes gpt_regs.svh offsets, the pin model and the bound checker
`timescale 1ns/1ns
`include "gpt_regs.svh"
module gpt_top_tb;
  typedef struct {logic [7:0] a; logic [31:0] rs; logic [31:0] d; logic [31:0] e;} gpt_row_t;
  logic clk = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic adc_trigger_out;
  logic irq_out;
  int n_errors = 0;
  int comparisons = 0;
  int h;
  gpt_row_t rows[13];
  ////////////////////////////////////////
  // 50 MHz clock
  always #10 clk = ~clk;
  gpt_top u_dut (.ref_clk_in(clk), .rst_b_in(rst_b_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .capture_compare_pwm_pin_in(pin_in), .capture_compare_pwm_pin_out(pin_out),
    .capture_compare_pwm_pin_oe_out(pin_oe), .adc_trigger_out(adc_trigger_out), .irq_out(irq_out));
  gpt_pin_model u_pins (.clk_in(clk), .pin_out(pin_in), .pwm_in(pin_out), .oe_in(pin_oe));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_flag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_flag
  // one bus cycle; signals are set once per edge, so strobes may run back to back
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk);
  endtask : bus
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  // data stands only in the cycle after the read edge; taken at the next edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, 1'b1, a, 32'h0);
    idle(1);
    chk(rdata_out, e);
  endtask : rd
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // edges until the next conversion trigger, bounded
  task automatic wait_adc(output int n);
    n = 0;
    do begin
      idle(1);
      n++;
    end while (adc_trigger_out !== 1'b1 && n < 300);
    if (n >= 300) begin
      n_errors++;
      tally_and_finish;
    end
  endtask : wait_adc
  // gap between two time-outs, then stop and clear
  task automatic period(input logic [7:0] a, input logic [31:0] c, input int exp);
    int n;
    wr(a, c);
    wait_adc(n);
    wait_adc(n);
    chk(n, exp);
    wr(a, 32'h0);
    idle(4);
    wr(`GPT_STAT_OFS, 32'h3F);
  endtask : period
  // high cycles of pin a over 40 cycles, a whole number of pwm periods
  task automatic pwm_case(input int exp);
    idle(8);
    h = u_pins.hi_cnt[0];
    idle(40);
    chk(u_pins.hi_cnt[0] - h, exp);
    chk({30'h0, pin_oe}, 32'h1);
  endtask : pwm_case
  ////////////////////////////////////////
  initial begin
    rows = '{'{`GPT_CFG_OFS, 32'h0, 32'hFFFF_FFE0, 32'h0}, '{`GPT_CTLA_OFS, 32'h0, 32'hABCD_5A20, 32'h5A20},
      '{`GPT_CTLB_OFS, 32'h0, 32'h1234_A530, 32'hA530}, '{`GPT_LOADA_OFS, 32'hFFFF, 32'hFFFF_0002, 32'h2},
      '{`GPT_LOADB_OFS, 32'hFFFF, 32'h2, 32'h2}, '{`GPT_MATCHA_OFS, 32'h0, 32'h0001_1234, 32'h1234},
      '{`GPT_MATCHB_OFS, 32'h0, 32'hC3, 32'hC3}, '{`GPT_VALA_OFS, 32'h0, 32'hFFFF, 32'h0},
      '{`GPT_CAPB_OFS, 32'h0, 32'hFFFF, 32'h0}, '{`GPT_VAL32_OFS, 32'h0, 32'hFFFF, 32'h0},
      '{8'h38, 32'h0, 32'hFFFF_FFFF, 32'h0}, '{`GPT_MASK_OFS, 32'h0, 32'hFFFF_FFC1, 32'h1},
      '{`GPT_STAT_OFS, 32'h0, 32'hFFFF_FFFF, 32'h0}};
    repeat (12) @(posedge clk);
    rst_b_in <= 1'b1;
    // reset value, write, read back of every register except VALB and CAPA, and one hole
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].rs);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(`GPT_CFG_OFS, 32'h10);
    period(`GPT_CTLA_OFS, 32'h0003, 3);
    period(`GPT_CTLA_OFS, 32'h0203, 9);
    period(`GPT_CTLB_OFS, 32'h0103, 6);
    // one-shot stops at zero; interrupt raised, masked and cleared
    wr(`GPT_CTLA_OFS, 32'h0001);
    idle(20);
    rd(`GPT_STAT_OFS, 32'h1);
    chk_flag(irq_out, 1'b1);
    rd(`GPT_VALA_OFS, 32'h0);
    wr(`GPT_MASK_OFS, 32'h0);
    idle(1);
    chk_flag(irq_out, 1'b0);
    wr(`GPT_MASK_OFS, 32'h1);
    idle(1);
    chk_flag(irq_out, 1'b1);
    wr(`GPT_STAT_OFS, 32'h1);
    idle(10);
    chk_flag(irq_out, 1'b0);
    rd(`GPT_STAT_OFS, 32'h0);
    wr(`GPT_CTLA_OFS, 32'h0);
    // half b counts falling pin edges: one edge short of time-out, then the second
    wr(`GPT_LOADB_OFS, 32'h1);
    wr(`GPT_CTLB_OFS, 32'h002B);
    u_pins.pulse(1, 3);
    rd(`GPT_STAT_OFS, 32'h0);
    u_pins.pulse(1, 2);
    idle(4);
    rd(`GPT_STAT_OFS, 32'h4);
    wr(`GPT_CTLB_OFS, 32'h0);
    wr(`GPT_STAT_OFS, 32'h3F);
    // capture on a rising edge of pin a
    wr(`GPT_LOADA_OFS, 32'hFFFF);
    wr(`GPT_CTLA_OFS, 32'h0005);
    u_pins.pulse(0, 3);
    idle(2);
    rd(`GPT_STAT_OFS, 32'h2);
    rd(`GPT_CAPA_OFS, 32'hFFFD);
    wr(`GPT_CTLA_OFS, 32'h0);
    wr(`GPT_STAT_OFS, 32'h3F);
    // pwm straight and inverted, then disabled
    wr(`GPT_LOADA_OFS, 32'h3);
    wr(`GPT_MATCHA_OFS, 32'h0);
    wr(`GPT_CTLA_OFS, 32'h0007);
    pwm_case(30);
    wr(`GPT_CTLA_OFS, 32'h0);
    wr(`GPT_CTLA_OFS, 32'h0017);
    pwm_case(10);
    wr(`GPT_CTLA_OFS, 32'h0010);
    idle(1);
    chk({30'h0, pin_oe}, 32'h0);
    // joined 32-bit timer, periodic then one-shot
    wr(`GPT_LOADA_OFS, 32'h4);
    wr(`GPT_LOADB_OFS, 32'h0);
    period(`GPT_CFG_OFS, 32'h1D, 5);
    wr(`GPT_CFG_OFS, 32'h15);
    idle(20);
    rd(`GPT_STAT_OFS, 32'h10);
    wr(`GPT_CFG_OFS, 32'h0);
    // real-time clock counts pin a edges up to the match
    wr(`GPT_LOADA_OFS, 32'h0);
    wr(`GPT_MATCHA_OFS, 32'h3);
    wr(`GPT_MATCHB_OFS, 32'h0);
    wr(`GPT_STAT_OFS, 32'h3F);
    wr(`GPT_CFG_OFS, 32'h06);
    repeat (3) u_pins.pulse(0, 2);
    idle(4);
    rd(`GPT_VAL32_OFS, 32'h3);
    rd(`GPT_STAT_OFS, 32'h20);
    wr(`GPT_CFG_OFS, 32'h0);
    // clock enable held low, then a reset in mid-run
    wr(`GPT_CTLA_OFS, 32'h0007);
    ce_in <= 1'b0;
    idle(3);
    ce_in <= 1'b1;
    idle(2);
    rst_b_in <= 1'b0;
    idle(2);
    chk({29'h0, irq_out, pin_oe}, 32'h0);
    rst_b_in <= 1'b1;
    rd(`GPT_CTLA_OFS, 32'h0);
    rd(`GPT_LOADA_OFS, 32'hFFFF);
    tally_and_finish;
  end
endmodule : gpt_top_tb
